// ===== verilog/fsp_regs.svh
// register offsets, field positions, reset values and address constants
// assumes inclusion by fsp_top only; offsets are byte addresses on APB
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH
`define FSP_OFF_OPTIONS 12'h000
`define FSP_OFF_CONFIG 12'h004
`define FSP_OFF_PROTECT 12'h008
`define FSP_OFF_STATUS 12'h00c
`define FSP_OPT_BACKDOOR 7
`define FSP_OPT_REDIR_DIS 6
`define FSP_CFG_KEY_ACCESS_ENABLE 5
`define FSP_PROT_DIS 0
`define FSP_STAT_VIOL 5
`define FSP_STAT_SECURE 0
`define FSP_SEC_UNSECURED 2'h2
`define FSP_KEY_BASE 16'hffb0
`define FSP_KEY_COUNT 4'h8
`define FSP_RST_BYTE 8'h00
`define FSP_RST_SEC 2'h0
`endif

// ===== verilog/fsp_pkg.sv
// types shared by the flash security and protection block
// assumes one bus clock domain for all users of these types
package fsp_pkg;
  // load from the nonvolatile bytes, then normal running
  typedef enum logic [0:0] {FSP_LOAD, FSP_RUN} fsp_state_e;
  // a write on the memory bus, or one forwarded to the command logic
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } fsp_cmd_s;
  // an erase or program request from the command sequencer
  typedef struct packed {
    logic mass;
    logic [15:0] addr;
  } fsp_op_s;
endpackage

// ===== verilog/fsp_top.sv
// flash security, option and protection control behind an APB slave
// assumes every input, the nonvolatile bytes included, is on CLOCK
`timescale 1ns/1ns
`include "fsp_regs.svh"
module fsp_top
  import fsp_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic DEBUG_ACCESS,
  input wire logic [7:0] OPTION_SOURCE_BYTE,
  input wire logic [7:0] PROTECTION_SOURCE_BYTE,
  input wire logic [63:0] BACKDOOR_KEY_BYTES,
  input wire logic MEM_WR,
  input wire fsp_cmd_s MEM_CMD,
  input wire logic MEM_SECURE_SRC,
  input wire logic MEM_DEBUG,
  output logic CMD_WR,
  output fsp_cmd_s CMD,
  input wire logic OP_REQ,
  input wire fsp_op_s OP,
  output logic OP_GO,
  input wire logic BLANK_OK,
  output logic SECURE,
  output logic BLOCK_UNSECURED_ACCESS,
  output logic VECTOR_REDIRECT_EN
);
  fsp_state_e state;
  logic backdoor_enable;
  logic redirection_disable;
  logic [1:0] security_code;
  logic key_access_enable;
  logic [6:0] protect_select;
  logic protection_disable;
  logic protection_violation_flag;
  logic [3:0] key_cnt;
  logic key_bad;
  logic key_wr_last;
  logic apb_wr;
  logic apb_hit;
  logic [31:0] next_rdata;
  logic key_range;
  logic key_wr;
  logic key_take;
  logic key_close;
  logic key_unlock;
  logic [15:0] prot_end;
  logic op_protected;
  logic [7:0] key_byte;
  logic [7:0] prot_wbyte;

  // zero-wait slave: every access phase completes in its first cycle
  assign PREADY = 1'b1;
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign apb_hit = (PADDR == `FSP_OFF_OPTIONS) || (PADDR == `FSP_OFF_CONFIG) ||
                   (PADDR == `FSP_OFF_PROTECT) || (PADDR == `FSP_OFF_STATUS);
  assign prot_wbyte = PWDATA[7:0];

  // one cycle of load after release so no port is sampled under reset
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      state <= FSP_LOAD;
    else
      state <= FSP_RUN;
  end

  // options image: loaded only in the load cycle, bus writes never reach it
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      backdoor_enable <= 1'b0;
      redirection_disable <= 1'b0;
    end
    else if (state == FSP_LOAD)
    begin
      backdoor_enable <= OPTION_SOURCE_BYTE[`FSP_OPT_BACKDOOR];
      redirection_disable <= OPTION_SOURCE_BYTE[`FSP_OPT_REDIR_DIS];
    end
  end

  // security code: reset image, then only ever moved to the unsecured pattern
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      security_code <= `FSP_RST_SEC;
    else if (state == FSP_LOAD)
      security_code <= OPTION_SOURCE_BYTE[1:0];
    else if (key_unlock || BLANK_OK)
      security_code <= `FSP_SEC_UNSECURED;
  end

  // only 1:0 is unsecured; secure state gates outside accesses
  assign SECURE = (security_code != `FSP_SEC_UNSECURED);
  assign BLOCK_UNSECURED_ACCESS = SECURE;
  assign VECTOR_REDIRECT_EN = !redirection_disable;

  // key access enable in the configuration register
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      key_access_enable <= 1'b0;
    else if (apb_wr && PADDR == `FSP_OFF_CONFIG)
      key_access_enable <= PWDATA[`FSP_CFG_KEY_ACCESS_ENABLE];
  end

  // key-range writes: while access is set, captured as key from secure non-debug sources, dropped otherwise; else commands
  assign key_range = MEM_CMD.addr[15:3] == 13'(`FSP_KEY_BASE >> 3);
  assign key_wr = MEM_WR && key_range && key_access_enable;
  assign key_take = key_wr && MEM_SECURE_SRC && !MEM_DEBUG;
  assign key_close = apb_wr && PADDR == `FSP_OFF_CONFIG && key_access_enable && !PWDATA[`FSP_CFG_KEY_ACCESS_ENABLE];
  assign key_byte = BACKDOOR_KEY_BYTES[{key_cnt[2:0], 3'h0} +: 8];
  // comparison fires as access falls; refused when backdoor disabled
  assign key_unlock = key_close && backdoor_enable && !key_bad && key_cnt == `FSP_KEY_COUNT;

  // key collector: order, value and spacing all must hold for a match
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      key_cnt <= 4'h0;
      key_bad <= 1'b0;
    end
    else if (!key_access_enable)
    begin
      key_cnt <= 4'h0;
      key_bad <= 1'b0;
    end
    else if (key_take)
    begin
      if (key_cnt == `FSP_KEY_COUNT || MEM_CMD.addr[2:0] != key_cnt[2:0] ||
          MEM_CMD.data != key_byte || key_wr_last)
        key_bad <= 1'b1;
      if (key_cnt != `FSP_KEY_COUNT)
        key_cnt <= key_cnt + 4'h1;
    end
  end

  // adjacent-cycle key writes are a sequence error, so remember the last one
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      key_wr_last <= 1'b0;
    else
      key_wr_last <= key_take;
  end

  // forward memory writes to the command logic unless they hit the key range while key access is set
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      CMD_WR <= 1'b0;
      CMD <= '0;
    end
    else
    begin
      CMD_WR <= MEM_WR && !key_wr;
      if (MEM_WR && !key_wr)
        CMD <= MEM_CMD;
    end
  end

  // protection register: reset image, then guarded writes
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      protect_select <= 7'h00;
      protection_disable <= 1'b0;
    end
    else if (state == FSP_LOAD)
    begin
      protect_select <= PROTECTION_SOURCE_BYTE[7:1];
      protection_disable <= PROTECTION_SOURCE_BYTE[`FSP_PROT_DIS];
    end
    else if (apb_wr && PADDR == `FSP_OFF_PROTECT)
    begin
      if (protection_disable || DEBUG_ACCESS)
      begin
        protect_select <= prot_wbyte[7:1];
        protection_disable <= prot_wbyte[`FSP_PROT_DIS];
      end
      else if (prot_wbyte[7:1] < protect_select && !prot_wbyte[`FSP_PROT_DIS])
        protect_select <= prot_wbyte[7:1];
    end
  end

  // unprotected flash ends at the selected 512-byte boundary
  assign prot_end = {protect_select, 9'h1ff};
  assign op_protected = !protection_disable && (OP.mass || OP.addr > prot_end);

  // erase and program gate: a protected request is dropped
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      OP_GO <= 1'b0;
    else
      OP_GO <= OP_REQ && !op_protected;
  end

  // violation flag: a new violation wins over a same-cycle write-one clear
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      protection_violation_flag <= 1'b0;
    else if (OP_REQ && op_protected)
      protection_violation_flag <= 1'b1;
    else if (apb_wr && PADDR == `FSP_OFF_STATUS && PWDATA[`FSP_STAT_VIOL])
      protection_violation_flag <= 1'b0;
  end

  // read mux; unused bits and upper bytes read zero
  always_comb
  begin
    next_rdata = 32'h0;
    if (PADDR == `FSP_OFF_OPTIONS)
      next_rdata[7:0] = {backdoor_enable, redirection_disable, 4'h0, security_code};
    else if (PADDR == `FSP_OFF_CONFIG)
      next_rdata[`FSP_CFG_KEY_ACCESS_ENABLE] = key_access_enable;
    else if (PADDR == `FSP_OFF_PROTECT)
      next_rdata[7:0] = {protect_select, protection_disable};
    else if (PADDR == `FSP_OFF_STATUS)
    begin
      next_rdata[`FSP_STAT_VIOL] = protection_violation_flag;
      next_rdata[`FSP_STAT_SECURE] = SECURE;
    end
  end

  // read data is caught in the setup cycle so a flip-flop carries it through the access phase;
  // limitation: a flag that moves between setup and access shows its setup-cycle value
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      PRDATA <= 32'h0;
    else if (PSEL && !PENABLE && !PWRITE)
      PRDATA <= next_rdata;
    else
      PRDATA <= 32'h0;
  end

  // error flag is a handshake output, decoded straight from the access phase
  assign PSLVERR = PSEL && PENABLE && !apb_hit;

  // checks

  property p_opt_stable;
    @(posedge CLOCK) disable iff (!RESETN)
    state == FSP_RUN |=> $stable(backdoor_enable) && $stable(redirection_disable);
  endproperty
  a_opt_stable: assert property (p_opt_stable) else $error("options changed after load");

  property p_sec_decode;
    @(posedge CLOCK) disable iff (!RESETN)
    state == FSP_LOAD |=> SECURE == ($past(OPTION_SOURCE_BYTE[1:0]) != `FSP_SEC_UNSECURED);
  endproperty
  a_sec_decode: assert property (p_sec_decode) else $error("security decode wrong");

  property p_no_key_when_off;
    @(posedge CLOCK) disable iff (!RESETN)
    state == FSP_RUN && !backdoor_enable && !BLANK_OK && SECURE |=> SECURE;
  endproperty
  a_no_key_when_off: assert property (p_no_key_when_off) else $error("unlocked with backdoor off");

  property p_debug_key;
    @(posedge CLOCK) disable iff (!RESETN)
    MEM_WR && MEM_DEBUG && key_access_enable |=> $stable(key_cnt);
  endproperty
  a_debug_key: assert property (p_debug_key) else $error("debug write reached key");

  property p_unlock;
    @(posedge CLOCK) disable iff (!RESETN)
    state == FSP_RUN && (key_unlock || BLANK_OK) |=> !SECURE [*2];
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock did not hold");

  property p_cmd_fwd;
    @(posedge CLOCK) disable iff (!RESETN)
    MEM_WR && key_range && !key_access_enable |=> CMD_WR && CMD.addr == $past(MEM_CMD.addr);
  endproperty
  a_cmd_fwd: assert property (p_cmd_fwd) else $error("key range write not forwarded");

  property p_key_capture;
    @(posedge CLOCK) disable iff (!RESETN)
    MEM_WR && key_range && key_access_enable |=> !CMD_WR;
  endproperty
  a_key_capture: assert property (p_key_capture) else $error("key write leaked as command");

  property p_no_shrink;
    @(posedge CLOCK) disable iff (!RESETN)
    state == FSP_RUN && !protection_disable && !DEBUG_ACCESS |=> protect_select <= $past(protect_select);
  endproperty
  a_no_shrink: assert property (p_no_shrink) else $error("protected region shrank");

  property p_protect_gate;
    @(posedge CLOCK) disable iff (!RESETN)
    OP_REQ && !protection_disable && OP.addr > {protect_select, 9'h1ff} |=> !OP_GO && protection_violation_flag;
  endproperty
  a_protect_gate: assert property (p_protect_gate) else $error("protected operation let through");

  property p_viol_set_wins;
    @(posedge CLOCK) disable iff (!RESETN)
    OP_REQ && op_protected |=> protection_violation_flag ##1 1'b1;
  endproperty
  a_viol_set_wins: assert property (p_viol_set_wins) else $error("violation lost");

  property p_redir;
    @(posedge CLOCK) disable iff (!RESETN)
    state == FSP_LOAD |=> VECTOR_REDIRECT_EN == !$past(OPTION_SOURCE_BYTE[`FSP_OPT_REDIR_DIS]);
  endproperty
  a_redir: assert property (p_redir) else $error("redirection decode wrong");

  c_key_unlock: cover property (@(posedge CLOCK) disable iff (!RESETN) key_unlock);
  c_violation: cover property (@(posedge CLOCK) disable iff (!RESETN) OP_REQ && op_protected);
  c_enlarge: cover property (@(posedge CLOCK) disable iff (!RESETN)
    state == FSP_RUN && $changed(protect_select) && !protection_disable);
endmodule

// ===== verification/flash_security_protection_bench.sv
// self-checking bench for the flash security, option and protection block
// assumes fsp_top answers APB with no wait and pulses CMD_WR, OP_GO one cycle late
`timescale 1ns/1ns
module flash_security_protection_bench;
  import fsp_pkg::*;
  logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, dbg = 0;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, prd;
  logic prdy, perr, cwr, go, sec, blk, redir;
  logic [7:0] opt_src = 0, prot_src = 0;
  logic [63:0] key = 0;
  logic mwr = 0, msec = 1, mdbg = 0, opreq = 0, blank = 0;
  fsp_cmd_s mcmd = '0, cmd;
  fsp_op_s op = '0;
  logic [32:0] rd_q[$];
  logic [32:0] cmd_q[$];
  logic [32:0] go_q[$];
  int fail_count = 0, num_checks = 0;

  fsp_top i_fsp_top (.CLOCK(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .DEBUG_ACCESS(dbg),
    .OPTION_SOURCE_BYTE(opt_src), .PROTECTION_SOURCE_BYTE(prot_src), .BACKDOOR_KEY_BYTES(key),
    .MEM_WR(mwr), .MEM_CMD(mcmd), .MEM_SECURE_SRC(msec), .MEM_DEBUG(mdbg), .CMD_WR(cwr),
    .CMD(cmd), .OP_REQ(opreq), .OP(op), .OP_GO(go), .BLANK_OK(blank), .SECURE(sec),
    .BLOCK_UNSECURED_ACCESS(blk), .VECTOR_REDIRECT_EN(redir));

  // 20 MHz bus clock
  initial
  begin
    forever #25 clk = ~clk;
  end

  task automatic check(string what, logic [32:0] exp, logic [32:0] got);
    num_checks++;
    if (exp !== got)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    if (rd_q.size() + cmd_q.size() + go_q.size() != 0)
    begin
      fail_count++;
      $display("ERROR pending results expected 0 seen %0d", rd_q.size() + cmd_q.size() + go_q.size());
    end
    if (fail_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // outputs are judged at the falling edge, where they have settled; an empty queue means an unexpected result
  always @(negedge clk)
  begin
    if (psel && pen && prdy && !pwr)
      check("read", rd_q.size() ? rd_q.pop_front() : 'x, {perr, prd});
    if (cwr)
      check("forwarded command", cmd_q.size() ? cmd_q.pop_front() : 'x, 33'(cmd));
    if (go)
      check("operation allowed", go_q.size() ? go_q.pop_front() : 'x, 33'(op.addr));
  end

  // apb master: request held until pready is seen high at a rising edge
  task automatic apb(logic w, logic [11:0] a, logic [7:0] d, logic dg = 0);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= {24'h0, d};
    dbg <= dg;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1 && n++ < 20);
    if (n >= 20)
    begin
      check("pready", 1, 0);
      complete_run();
    end
    psel <= 0;
    pen <= 0;
    dbg <= 0;
  endtask

  task automatic rd(logic [11:0] a, logic [7:0] e, logic err = 0);
    rd_q.push_back({err, 24'h0, e});
    apb(0, a, 8'h00);
  endtask

  // memory write followed by an idle cycle, so key writes never sit on adjacent cycles
  task automatic mw(logic [15:0] a, logic [7:0] d, logic fwd, logic dg = 0);
    if (fwd)
      cmd_q.push_back(33'({a, d}));
    @(posedge clk);
    mwr <= 1;
    mcmd <= {a, d};
    mdbg <= dg;
    msec <= !dg;
    @(posedge clk);
    mwr <= 0;
    @(posedge clk);
  endtask

  task automatic opr(logic mass, logic [15:0] a, logic ok);
    if (ok)
      go_q.push_back(33'(a));
    @(posedge clk);
    opreq <= 1;
    op <= {mass, a};
    @(posedge clk);
    opreq <= 0;
    @(posedge clk);
  endtask

  // key entry with a stray debug write in the middle, which must be dropped
  task automatic unlock(logic [63:0] k);
    apb(1, 12'h004, 8'h20);
    for (int i = 0; i < 8; i++)
    begin
      if (i == 3)
        mw(16'hffb3, ~k[8*i+:8], 0, 1);
      mw(16'(16'hffb0 + i), k[8*i+:8], 0);
    end
    apb(1, 12'h004, 8'h00);
    @(posedge clk);
  endtask

  task automatic do_reset(logic [7:0] o, logic [7:0] p);
    @(posedge clk);
    rstn <= 0;
    opt_src <= o;
    prot_src <= p;
    repeat (6) @(posedge clk);
    rstn <= 1;
    repeat (2) @(posedge clk);
  endtask

  task automatic lvl(logic s, logic r);
    @(negedge clk);
    check("secure", s, sec);
    check("block access", s, blk);
    check("redirect enable", r, redir);
  endtask

  // main sequence: backdoor off first, then a fresh reset with it on
  initial
  begin
    logic [7:0] o;
    void'($urandom(71));
    key = {$urandom, $urandom};
    o = 8'h40 | (8'($urandom) & 8'h3c);
    for (int c = 0; c < 4; c++)
    begin
      do_reset(o | 8'(c), 8'h80);
      lvl(c != 2, 0);
    end
    do_reset(o, 8'h80);
    rd(12'h000, o & 8'hc3);
    apb(1, 12'h000, 8'hff);
    rd(12'h000, o & 8'hc3);
    rd(12'h010, 8'h00, 1);
    unlock(key);
    lvl(1, 0);
    @(posedge clk);
    blank <= 1;
    @(posedge clk);
    blank <= 0;
    lvl(0, 0);
    rd(12'h008, 8'h80);
    apb(1, 12'h008, 8'h82);
    rd(12'h008, 8'h80);
    apb(1, 12'h008, 8'h7e);
    rd(12'h008, 8'h7e);
    opr(0, 16'h7fff, 1);
    opr(0, 16'h8000, 0);
    rd(12'h00c, 8'h20);
    apb(1, 12'h00c, 8'h20);
    rd(12'h00c, 8'h00);
    opr(1, 16'h0000, 0);
    apb(1, 12'h008, 8'h81, 1);
    rd(12'h008, 8'h81);
    opr(1, 16'h0000, 1);
    apb(1, 12'h008, 8'hfe);
    rd(12'h008, 8'hfe);
    mw(16'hffb5, 8'($urandom), 1);
    rd(12'h004, 8'h00);
    apb(1, 12'h004, 8'hff);
    rd(12'h004, 8'h20);
    apb(1, 12'h004, 8'h00);
    o = (o & 8'h3c) | 8'h80;
    do_reset(o, 8'h80);
    lvl(1, 1);
    rd(12'h000, o & 8'hc3);
    rd(12'h008, 8'h80);
    unlock(key ^ 64'h1);
    lvl(1, 1);
    unlock(key);
    lvl(0, 1);
    complete_run();
  end
endmodule
